/* sfim_checker_properties.sv */
/* Assertions on sfim_status_irq ports. Assumes the bind below. */
`timescale 1ns/10ps
`default_nettype none
module sfim_checker
    import sfim_pkg::*;
(
    // Watched ports
    input wire logic core_clk,
    input wire logic reset,
    input wire sfim_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata_q,
    input wire sfim_events_t events,
    input wire logic diag_measure_done,
    input wire logic [7:0] diag_impedance,
    input wire logic playback_active,
    input wire logic [7:0] supply_sample,
    input wire sfim_pin_mode_t pin_mode,
    input wire logic trigger_irq_pin_oe_n
);
    localparam logic [7:0] ST = SFIM_ADDR_STATUS;
    localparam logic [7:0] MK = SFIM_ADDR_MASK;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_rd(logic [7:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    sequence s_int;
        pin_mode == SFIM_PIN_INTERRUPT && !reg_req.wr;
    endsequence
    property p_done;
        events.done ##1 s_rd(ST) |=> reg_rdata_q[3];
    endproperty
    a_done: assert property (p_done) else $error("done lost");
    property p_clr;
        (s_rd(ST) and !events.done) ##1 (s_rd(ST) and !events.done) |=> !reg_rdata_q[3];
    endproperty
    a_clr: assert property (p_clr) else $error("done not cleared");
    property p_keep;
        (s_rd(ST) and events.done) ##1 s_rd(ST) |=> reg_rdata_q[3];
    endproperty
    a_keep: assert property (p_keep) else $error("event lost to read");
    property p_imp;
        diag_measure_done ##1 (s_rd(SFIM_ADDR_IMPEDANCE) and !diag_measure_done)
            |=> reg_rdata_q == $past(diag_impedance, 2);
    endproperty
    a_imp: assert property (p_imp) else $error("impedance wrong");
    property p_sup;
        (s_rd(SFIM_ADDR_SUPPLY) and $past(playback_active))
            |=> reg_rdata_q == $past(supply_sample, 2);
    endproperty
    a_sup: assert property (p_sup) else $error("supply wrong");
    property p_mrb;
        reg_req.wr && reg_req.addr == MK ##1 s_rd(MK)
            |=> reg_rdata_q == {3'h0, $past(reg_req.wdata[4:0], 2)};
    endproperty
    a_mrb: assert property (p_mrb) else $error("mask readback wrong");
    property p_mode;
        pin_mode != SFIM_PIN_INTERRUPT [*2] |-> trigger_irq_pin_oe_n;
    endproperty
    a_mode: assert property (p_mode) else $error("pin driven outside irq mode");
    property p_irq;
        reg_req.wr && reg_req.addr == MK && reg_req.wdata == 8'h00 ##1 (s_int and events.thermal)
            ##1 s_int |=> !trigger_irq_pin_oe_n;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");
endmodule
bind sfim_status_irq sfim_checker chk (.*);
`default_nettype wire

/* sfim_host_pin.sv */
/* Host-side view of the shared trigger/interrupt pin. Assumes a pull-up on the wire. */
`timescale 1ns/10ps
`default_nettype none
module sfim_host_pin
(
    // Pin driver from the device
    input wire logic pin_o,
    input wire logic oe_n,
    // Level seen by the host
    output logic irq_line
);
    // The pull-up holds the line high whenever the device lets go.
    assign irq_line = oe_n ? 1'b1 : pin_o;
endmodule
`default_nettype wire

/* sfim_pkg.sv */
/*
 * Package for the status-flag and interrupt-suppress block: register
 * offsets, field positions, reset values and the carrier types.
 * Assumes an 8-bit register port driven by the control interface logic.
 */
package sfim_pkg;
    localparam logic [7:0] SFIM_ADDR_STATUS = 8'h01;
    localparam logic [7:0] SFIM_ADDR_MASK = 8'h02;
    localparam logic [7:0] SFIM_ADDR_IMPEDANCE = 8'h03;
    localparam logic [7:0] SFIM_ADDR_SUPPLY = 8'h04;

    localparam int SFIM_BIT_OVERCURRENT = 0;
    localparam int SFIM_BIT_THERMAL = 1;
    localparam int SFIM_BIT_DROOP = 2;
    localparam int SFIM_BIT_DONE = 3;
    localparam int SFIM_BIT_FORMAT = 4;
    localparam int SFIM_BIT_DIAG = 7;
    localparam int SFIM_MASK_W = 5;

    localparam logic [4:0] SFIM_MASK_RESET = 5'h18;
    localparam logic [7:0] SFIM_BYTE_RESET = 8'h00;
    localparam logic [7:0] SFIM_STATUS_USED = 8'h9F;

    // Pin function of the shared trigger/interrupt pin.
    typedef enum logic [1:0] {
        SFIM_PIN_EXT_EDGE = 2'h0,
        SFIM_PIN_EXT_LEVEL = 2'h1,
        SFIM_PIN_INTERRUPT = 2'h2,
        SFIM_PIN_RESERVED = 2'h3
    } sfim_pin_mode_t;

    // One-cycle event strobes from the engine, protection and sequencer.
    typedef struct packed {
        logic overcurrent_pos;
        logic overcurrent_neg;
        logic thermal;
        logic droop;
        logic done;
        logic format_error;
        logic diag_fail;
    } sfim_events_t;

    // Register port from the control interface.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfim_reg_req_t;
endpackage

/* sfim_status_irq.sv */
/*
 * Status flags, interrupt-suppress mask, diagnostic impedance and supply
 * readings, and the shared trigger/interrupt pin driver.
 * Assumes events arrive as one-cycle strobes synchronous to core_clk and
 * that the control interface presents one-cycle read and write strobes.
 */
// Function
// - Operation-complete flag set on finish, read-cleared
// - Done bit zero unless a finished process pends
// - Droop flag latches below threshold, read-cleared
// - Thermal flag latches on over-temperature, read-cleared
// - Overcurrent on either output latches, read-cleared
// - Mask acts only in interrupt pin mode
// - Mask bits suppress overcurrent..format-error interrupts
// - Hold eight-bit impedance after diagnostics
// - Eight-bit supply reading, held while playback is inactive
// - Supply reading updates only during playback
// - Format-error flag latches, read-cleared
// - Diagnostic-fail flag latches, read-cleared
`timescale 1ns/10ps
`default_nettype none
module sfim_status_irq
    import sfim_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire sfim_reg_req_t reg_req,
    output logic [7:0] reg_rdata_q,
    // Events and measurements
    input wire sfim_events_t events,
    input wire logic diag_measure_done,
    input wire logic [DATA_W-1:0] diag_impedance,
    input wire logic playback_active,
    input wire logic [DATA_W-1:0] supply_sample,
    // Pin configuration and pin
    input wire sfim_pin_mode_t pin_mode,
    output logic trigger_irq_pin_o,
    output logic trigger_irq_pin_oe_n
);
    // Elaboration checks: the register map is byte wide and the mask field
    // must be no wider than its register.
    if (DATA_W != 8)
    begin : g_bad_data_w
        $error("sfim_status_irq: DATA_W must be 8");
    end
    if (SFIM_MASK_W > DATA_W)
    begin : g_bad_mask_w
        $error("sfim_status_irq: mask field wider than a register");
    end

    logic [7:0] flags;
    logic [7:0] set_vec;
    logic status_rd;
    logic [4:0] interrupt_suppress_field_q;
    logic [7:0] impedance_q;
    logic [7:0] supply_q;
    logic [4:0] pending;
    logic irq_active;
    logic [7:0] rdata_d;
    logic sel_status;
    logic sel_mask;
    logic sel_impedance;
    logic sel_supply;
    logic mask_wr;
    localparam logic [DATA_W-SFIM_MASK_W-1:0] MASK_PAD = '0;

    // One address decode serves the write, read-clear and read-back paths.
    assign sel_status = (reg_req.addr == SFIM_ADDR_STATUS);
    assign sel_mask = (reg_req.addr == SFIM_ADDR_MASK);
    assign sel_impedance = (reg_req.addr == SFIM_ADDR_IMPEDANCE);
    assign sel_supply = (reg_req.addr == SFIM_ADDR_SUPPLY);
    assign status_rd = reg_req.rd && sel_status;
    assign mask_wr = reg_req.wr && sel_mask;

    always_comb
    begin
        set_vec = 8'h00;
        set_vec[SFIM_BIT_OVERCURRENT] = events.overcurrent_pos
            | events.overcurrent_neg;
        set_vec[SFIM_BIT_THERMAL] = events.thermal;
        set_vec[SFIM_BIT_DROOP] = events.droop;
        set_vec[SFIM_BIT_DONE] = events.done;
        set_vec[SFIM_BIT_FORMAT] = events.format_error;
        set_vec[SFIM_BIT_DIAG] = events.diag_fail;
    end

    // One sticky flag per used status bit; unused bits read zero.
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++)
        begin : g_flag
            if (SFIM_STATUS_USED[gi])
            begin : g_used
                sfim_sticky_flag u_flag
                (
                    .core_clk(core_clk),
                    .reset(reset),
                    .set_evt(set_vec[gi]),
                    .clr_rd(status_rd),
                    .flag_q(flags[gi])
                );
            end
            else
            begin : g_unused
                assign flags[gi] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            interrupt_suppress_field_q <= SFIM_MASK_RESET;
        end
        else if (mask_wr)
        begin
            interrupt_suppress_field_q <= reg_req.wdata[SFIM_MASK_W-1:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            impedance_q <= SFIM_BYTE_RESET;
        end
        else if (diag_measure_done)
        begin
            impedance_q <= diag_impedance;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            supply_q <= SFIM_BYTE_RESET;
        end
        else if (playback_active)
        begin
            supply_q <= supply_sample;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            reg_rdata_q <= SFIM_BYTE_RESET;
        end
        else
        begin
            reg_rdata_q <= rdata_d;
        end
    end

    // Read data mux; a cycle without a read strobe keeps the last value.
    always_comb
    begin
        rdata_d = reg_rdata_q;
        if (reg_req.rd)
        begin
            if (sel_status)
            begin
                rdata_d = flags;
            end
            else if (sel_mask)
            begin
                rdata_d = {MASK_PAD, interrupt_suppress_field_q};
            end
            else if (sel_impedance)
            begin
                rdata_d = impedance_q;
            end
            else if (sel_supply)
            begin
                rdata_d = supply_q;
            end
            else
            begin
                rdata_d = SFIM_BYTE_RESET;
            end
        end
    end

    // The pin follows the unmasked flags one cycle late, so a read that
    // clears the last of them releases the pin at the following edge.
    always_comb
    begin
        pending = flags[SFIM_MASK_W-1:0] & ~interrupt_suppress_field_q;
        irq_active = |pending;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            trigger_irq_pin_o <= 1'b1;
            trigger_irq_pin_oe_n <= 1'b1;
        end
        else if (pin_mode == SFIM_PIN_INTERRUPT)
        begin
            trigger_irq_pin_o <= 1'b0;
            trigger_irq_pin_oe_n <= ~irq_active;
        end
        else
        begin
            trigger_irq_pin_o <= 1'b1;
            trigger_irq_pin_oe_n <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* sfim_sticky_flag.sv */
/*
 * One sticky status flag, set by an event and cleared by a status read.
 * Assumes the read strobe is one cycle long.
 */
`timescale 1ns/10ps
`default_nettype none
module sfim_sticky_flag
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic set_evt,
    input wire logic clr_rd,
    // State
    output logic flag_q
);
    logic flag_d;

    // A set in the clearing cycle wins, so the new event survives.
    always_comb
    begin
        flag_d = flag_q;
        if (set_evt)
        begin
            flag_d = 1'b1;
        end
        else if (clr_rd)
        begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
/* Testbench for sfim_status_irq with a host pin model. Assumes sfim_pkg. */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import sfim_pkg::*;
;
    localparam logic [7:0] ST = SFIM_ADDR_STATUS;
    localparam logic [7:0] BITS [7] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic dmd = 1'b0;
    logic pb = 1'b0;
    logic [7:0] imp = 8'h00;
    logic [7:0] sup = 8'h00;
    logic [7:0] rdata;
    logic pin_o, oe_n, irq_line;
    sfim_reg_req_t req = '0;
    sfim_events_t ev = '0;
    sfim_pin_mode_t mode = SFIM_PIN_INTERRUPT;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    sfim_status_irq dut (.core_clk(core_clk), .reset(reset), .reg_req(req), .reg_rdata_q(rdata),
        .events(ev), .diag_measure_done(dmd), .diag_impedance(imp), .playback_active(pb),
        .supply_sample(sup), .pin_mode(mode), .trigger_irq_pin_o(pin_o),
        .trigger_irq_pin_oe_n(oe_n));
    sfim_host_pin host (.pin_o(pin_o), .oe_n(oe_n), .irq_line(irq_line));
    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fail_count++;
            finish_test();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: pin %b want %b", $time, got, exp);
        end
    endtask
    // Holds the read strobe n cycles, the event for the first only.
    task rd(input logic [7:0] a, input sfim_events_t e, input int n, input logic [7:0] exp);
        req.rd <= 1'b1;
        req.addr <= a;
        ev <= e;
        @(posedge core_clk);
        ev <= '0;
        repeat (n - 1) @(posedge core_clk);
        req.rd <= 1'b0;
        @(posedge core_clk);
        chk(rdata, exp);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task t_regs;
        for (int i = 1; i < 6; i++) rd(i[7:0], '0, 1, i == 2 ? 8'h18 : 8'h00);
        wr(SFIM_ADDR_IMPEDANCE, 8'hFF);
        rd(SFIM_ADDR_IMPEDANCE, '0, 1, 8'h00);
        $display("regs done");
    endtask
    task t_flags;
        for (int i = 0; i < 7; i++)
        begin
            rd(8'h07, 7'h40 >> i, 1, 8'h00);
            rd(ST, '0, 1, BITS[i]);
            rd(ST, '0, 2, 8'h00);
        end
        rd(ST, 7'h04, 2, 8'h08);
        $display("flags done");
    endtask
    task t_mask;
        wr(SFIM_ADDR_MASK, 8'hFF);
        rd(SFIM_ADDR_MASK, '0, 1, 8'h1F);
        rd(8'h07, 7'h10, 1, 8'h00);
        @(posedge core_clk);
        chk_pin(irq_line, 1'b1);
        wr(SFIM_ADDR_MASK, 8'h00);
        rd(8'h07, 7'h10, 1, 8'h00);
        @(posedge core_clk);
        chk_pin(irq_line, 1'b0);
        mode <= SFIM_PIN_EXT_LEVEL;
        repeat (2) @(posedge core_clk);
        chk_pin(irq_line, 1'b1);
        mode <= SFIM_PIN_INTERRUPT;
        rd(ST, '0, 1, 8'h02);
        @(posedge core_clk);
        chk_pin(irq_line, 1'b1);
        $display("mask done");
    endtask
    task t_meas;
        dmd <= 1'b1;
        imp <= 8'hA5;
        @(posedge core_clk);
        dmd <= 1'b0;
        imp <= 8'h3C;
        rd(SFIM_ADDR_IMPEDANCE, '0, 1, 8'hA5);
        pb <= 1'b1;
        sup <= 8'h5A;
        @(posedge core_clk);
        rd(SFIM_ADDR_SUPPLY, '0, 1, 8'h5A);
        pb <= 1'b0;
        sup <= 8'h11;
        repeat (2) @(posedge core_clk);
        rd(SFIM_ADDR_SUPPLY, '0, 1, 8'h5A);
        $display("meas done");
    endtask
    task finish_test;
        $display("checks %0d fails %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_flags();
        t_mask();
        t_meas();
        finish_test();
    end
endmodule
`default_nettype wire
